// ===== rwsc_top.v
// reset, power-on reset, write lock, wake indicator and strap control
`timescale 1ns/100ps
`include "rwsc_consts.vh"
module rwsc_top #(
    parameter [31:0] BYTE_TEST_VAL = 32'h0a5a_5a0a, // arbitrary test pattern
    parameter POR_TICKS = `RWSC_POR_TICKS
) (
    input wire ref_clk,
    input wire rst_n,
    input wire hw_reset_pin_low,
    input wire chip_select_low,
    input wire write_strobe_low,
    input wire crossover_auto_strap,
    input wire speed_sel_strap,
    input wire ref_osc_in,
    input wire wake_event_in,
    input wire [7:0] reg_addr,
    input wire [31:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [31:0] reg_rdata,
    output reg irq_out,
    output reg wake_indicator_out,
    output reg wake_indicator_oe,
    output reg ref_osc_out,
    output reg crossover_en,
    output reg link_speed_100,
    output reg link_full_duplex,
    output reg link_autoneg_en,
    output reg power_save,
    output reg sys_reset_out
);
    localparam NSYNC = 6;
    localparam POR_LAST = POR_TICKS - 1;

    // synchronised pin levels
    wire [NSYNC-1:0] pin_raw;
    wire [NSYNC-1:0] pin_sync;
    wire hw_rst_low_s;
    wire cs_low_s;
    wire wr_low_s;
    wire xover_s;
    wire speed_s;
    wire osc_s;

    assign pin_raw = {ref_osc_in, speed_sel_strap, crossover_auto_strap,
                      write_strobe_low, chip_select_low, hw_reset_pin_low};
    assign hw_rst_low_s = pin_sync[0];
    assign cs_low_s = pin_sync[1];
    assign wr_low_s = pin_sync[2];
    assign xover_s = pin_sync[3];
    assign speed_s = pin_sync[4];
    assign osc_s = pin_sync[5];

    // one synchroniser per pin; reset value 1 keeps pulled-up pins inactive
    genvar gi;
    generate
        for (gi = 0; gi < NSYNC; gi = gi + 1) begin : g_sync
            rwsc_sync #(
                .RST_VAL(1'b1)
            ) u_sync (
                .ref_clk(ref_clk),
                .rst_n(rst_n),
                .pin_in(pin_raw[gi]),
                .level_q(pin_sync[gi])
            );
        end
    endgenerate

    // 25 MHz timing tick from the fast clock
    reg [1:0] div_q;
    reg tick_q;
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            div_q <= 2'h0;
            tick_q <= 1'b0;
        end else begin
            tick_q <= (div_q == `RWSC_TICK_DIV - 1);
            if (div_q == `RWSC_TICK_DIV - 1) begin
                div_q <= 2'h0;
            end else begin
                div_q <= div_q + 2'h1;
            end
        end
    end

    // internal power-on reset: holds the block until the count expires
    reg [8:0] por_cnt_q;
    reg por_busy_q;
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            por_cnt_q <= 9'h000;
            por_busy_q <= 1'b1;
        end else if (por_busy_q && tick_q) begin
            if (por_cnt_q == POR_LAST) begin
                por_busy_q <= 1'b0;
            end else begin
                por_cnt_q <= por_cnt_q + 9'h001;
            end
        end
    end

    // combined internal reset: power-on or reset pin held low
    wire sys_rst;
    reg sys_rst_q;
    assign sys_rst = por_busy_q | ~hw_rst_low_s;
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            sys_rst_q <= 1'b1;
        end else begin
            sys_rst_q <= sys_rst;
        end
    end
    wire rst_release;
    assign rst_release = sys_rst_q & ~sys_rst;

    // host write cycle on the pins: both strobes low, counted on the edge
    reg host_wr_q;
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            host_wr_q <= 1'b0;
        end else begin
            host_wr_q <= ~cs_low_s & ~wr_low_s;
        end
    end
    wire host_wr_start;
    assign host_wr_start = ~cs_low_s & ~wr_low_s & ~host_wr_q;

    // control, status, mask, power save and write lock
    reg [3:0] ctrl_q;
    reg [3:0] ctrl_d;
    reg [`RWSC_ST_WIDTH-1:0] stat_q;
    reg [`RWSC_ST_WIDTH-1:0] stat_d;
    reg [`RWSC_ST_WIDTH-1:0] mask_q;
    reg [`RWSC_ST_WIDTH-1:0] mask_d;
    reg sleep_q;
    reg sleep_d;
    reg locked_q;
    reg locked_d;
    reg speed_latch_q;
    wire wake_exit;
    wire wr_ok;

    // any host write wakes the device, whatever the address or data
    assign wake_exit = sleep_q & (host_wr_start | reg_wr);
    // writes take effect only when awake and unlocked
    assign wr_ok = reg_wr & ~sleep_q & ~locked_q;

    // next-state logic for the software-visible state
    always @* begin
        ctrl_d = ctrl_q;
        mask_d = mask_q;
        stat_d = stat_q;
        sleep_d = sleep_q;
        locked_d = locked_q;
        if (wr_ok && reg_addr == `RWSC_OFF_CTRL) begin
            ctrl_d = reg_wdata[3:0];
        end
        if (wr_ok && reg_addr == `RWSC_OFF_MASK) begin
            mask_d = reg_wdata[`RWSC_ST_WIDTH-1:0];
        end
        if (wr_ok && reg_addr == `RWSC_OFF_STATUS) begin
            stat_d = stat_q & ~reg_wdata[`RWSC_ST_WIDTH-1:0];
        end
        // events set after the clear so a same-cycle event wins
        if (wake_event_in && sleep_q) begin
            stat_d[`RWSC_ST_WAKE_EVT] = 1'b1;
        end
        if (wake_exit) begin
            stat_d[`RWSC_ST_HOST_WAKE] = 1'b1;
        end
        // sleep request bit enters power save; wake event alone never exits
        if (wr_ok && reg_addr == `RWSC_OFF_CTRL && reg_wdata[`RWSC_CTRL_SLEEP]) begin
            sleep_d = 1'b1;
        end
        if (wake_exit) begin
            sleep_d = 1'b0;
        end
        ctrl_d[`RWSC_CTRL_SLEEP] = sleep_d;
        // lock: a completed read clears it, a wake exit sets it again
        if (reg_rd) begin
            locked_d = 1'b0;
        end
        if (wake_exit) begin
            locked_d = 1'b1;
        end
    end

    // state registers, returned to reset values by the internal reset
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_q <= `RWSC_CTRL_RST;
            stat_q <= `RWSC_MASK_RST;
            mask_q <= `RWSC_MASK_RST;
            sleep_q <= 1'b0;
            locked_q <= 1'b1;
        end else if (sys_rst) begin
            ctrl_q <= `RWSC_CTRL_RST;
            stat_q <= `RWSC_MASK_RST;
            mask_q <= `RWSC_MASK_RST;
            sleep_q <= 1'b0;
            locked_q <= 1'b1;
        end else begin
            ctrl_q <= ctrl_d;
            stat_q <= stat_d;
            mask_q <= mask_d;
            sleep_q <= sleep_d;
            locked_q <= locked_d;
        end
    end

    // speed strap captured on the cycle the internal reset releases
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            speed_latch_q <= 1'b0;
        end else if (rst_release) begin
            speed_latch_q <= speed_s;
        end
    end

    // wake indicator level, polarity and drive type
    wire wake_active;
    wire wake_level;
    wire wake_od;
    assign wake_active = ctrl_q[`RWSC_CTRL_WAKE_EN] & stat_q[`RWSC_ST_WAKE_EVT];
    assign wake_level = wake_active ~^ ctrl_q[`RWSC_CTRL_WAKE_POL];
    assign wake_od = ctrl_q[`RWSC_CTRL_WAKE_OD];

    // read mux
    reg [31:0] rdata_d;
    always @* begin
        rdata_d = 32'h0000_0000;
        case (reg_addr)
            `RWSC_OFF_CTRL: begin
                rdata_d[3:0] = ctrl_q;
            end
            `RWSC_OFF_STATUS: begin
                rdata_d[`RWSC_ST_WIDTH-1:0] = stat_q;
            end
            `RWSC_OFF_MASK: begin
                rdata_d[`RWSC_ST_WIDTH-1:0] = mask_q;
            end
            `RWSC_OFF_STATE: begin
                rdata_d[`RWSC_SS_SLEEP] = sleep_q;
                rdata_d[`RWSC_SS_LOCKED] = locked_q;
                rdata_d[`RWSC_SS_XOVER] = crossover_en;
                rdata_d[`RWSC_SS_SPEED_STRAP] = speed_latch_q;
                rdata_d[`RWSC_SS_SPEED_100] = link_speed_100;
                rdata_d[`RWSC_SS_FULL_DUPLEX] = link_full_duplex;
                rdata_d[`RWSC_SS_AUTONEG] = link_autoneg_en;
            end
            `RWSC_OFF_BYTE_TEST: begin
                rdata_d = BYTE_TEST_VAL;
            end
            default: begin
                rdata_d = 32'h0000_0000;
            end
        endcase
    end

    // registered outputs
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= 32'h0000_0000;
            irq_out <= 1'b0;
            wake_indicator_out <= 1'b0;
            wake_indicator_oe <= 1'b0;
            ref_osc_out <= 1'b0;
            crossover_en <= 1'b0;
            link_speed_100 <= 1'b0;
            link_full_duplex <= 1'b0;
            link_autoneg_en <= 1'b0;
            power_save <= 1'b0;
            sys_reset_out <= 1'b1;
        end else begin
            if (reg_rd) begin
                reg_rdata <= rdata_d;
            end else begin
                reg_rdata <= 32'h0000_0000;
            end
            irq_out <= |(stat_q & mask_q);
            // open drain drives only a low level; push-pull always drives
            if (wake_od) begin
                wake_indicator_out <= 1'b0;
                wake_indicator_oe <= ~wake_level;
            end else begin
                wake_indicator_out <= wake_level;
                wake_indicator_oe <= 1'b1;
            end
            ref_osc_out <= ~osc_s;
            crossover_en <= xover_s;
            link_speed_100 <= speed_latch_q;
            link_full_duplex <= `RWSC_DUPLEX_DEFAULT;
            link_autoneg_en <= speed_latch_q;
            power_save <= sleep_q;
            sys_reset_out <= sys_rst;
        end
    end
endmodule

// ===== rwsc_consts.vh
// constants for the reset, wake and strap control block
`ifndef RWSC_CONSTS_VH
`define RWSC_CONSTS_VH

// clock and timing
`define RWSC_REF_CLK_MHZ 100
`define RWSC_OSC_MHZ 25
`define RWSC_TICK_DIV (`RWSC_REF_CLK_MHZ / `RWSC_OSC_MHZ)
`define RWSC_POR_US 10
`define RWSC_POR_TICKS (`RWSC_POR_US * `RWSC_OSC_MHZ)

// register offsets (byte addresses)
`define RWSC_OFF_CTRL 8'h00
`define RWSC_OFF_STATUS 8'h04
`define RWSC_OFF_MASK 8'h08
`define RWSC_OFF_STATE 8'h0c
`define RWSC_OFF_BYTE_TEST 8'h10

// control register fields
`define RWSC_CTRL_WAKE_EN 0
`define RWSC_CTRL_WAKE_POL 1
`define RWSC_CTRL_WAKE_OD 2
`define RWSC_CTRL_SLEEP 3
`define RWSC_CTRL_RST 4'h0

// status and mask fields
`define RWSC_ST_WAKE_EVT 0
`define RWSC_ST_HOST_WAKE 1
`define RWSC_ST_WIDTH 2
`define RWSC_MASK_RST 2'h0

// state register fields
`define RWSC_SS_SLEEP 0
`define RWSC_SS_LOCKED 1
`define RWSC_SS_XOVER 2
`define RWSC_SS_SPEED_STRAP 3
`define RWSC_SS_SPEED_100 4
`define RWSC_SS_FULL_DUPLEX 5
`define RWSC_SS_AUTONEG 6

// default link duplex setting, the same whatever the latched speed strap
`define RWSC_DUPLEX_DEFAULT 1'b0

`endif

// ===== rwsc_sync.v
// three-stage input synchroniser with agreement filter
`timescale 1ns/100ps
module rwsc_sync #(
    parameter RST_VAL = 1'b0
) (
    input wire ref_clk,
    input wire rst_n,
    input wire pin_in,
    output reg level_q
);
    reg s1_q;
    reg s2_q;
    reg s3_q;

    // first stage feeds only the second; output follows once stages 2 and 3 agree
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            s1_q <= RST_VAL;
            s2_q <= RST_VAL;
            s3_q <= RST_VAL;
            level_q <= RST_VAL;
        end else begin
            s1_q <= pin_in;
            s2_q <= s1_q;
            s3_q <= s2_q;
            if (s2_q == s3_q) begin
                level_q <= s3_q;
            end
        end
    end
endmodule

// ===== rwsc_top_asserts.sv
// port-level assertions for the reset, wake and strap block
`timescale 1ns/100ps
module rwsc_top_asserts (
    input logic ref_clk,
    input logic rst_n,
    input logic hw_reset_pin_low,
    input logic chip_select_low,
    input logic write_strobe_low,
    input logic crossover_auto_strap,
    input logic wake_event_in,
    input logic reg_wr,
    input logic wake_indicator_out,
    input logic wake_indicator_oe,
    input logic crossover_en,
    input logic link_speed_100,
    input logic link_full_duplex,
    input logic link_autoneg_en,
    input logic power_save,
    input logic sys_reset_out
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    // host write cycle held on the pins
    sequence s_pin_wr;
        (!chip_select_low && !write_strobe_low && !sys_reset_out) [*8];
    endsequence
    // no write of any kind for a while
    sequence s_quiet;
        (chip_select_low && write_strobe_low && !reg_wr && !sys_reset_out) [*6];
    endsequence
    AST_PIN_RST: assert property (!hw_reset_pin_low [*8] |-> sys_reset_out)
        else $error("reset pin ignored");
    AST_EVT_STAY: assert property (s_quiet ##0 (power_save && wake_event_in) |=> power_save)
        else $error("wake event left power save");
    AST_REG_WAKE: assert property (power_save && reg_wr |-> ##[1:2] !power_save)
        else $error("bus write did not wake");
    AST_PIN_WAKE: assert property (s_pin_wr |-> ##[0:4] !power_save)
        else $error("pin write did not wake");
    AST_XOVER: assert property ((!sys_reset_out && $stable(crossover_auto_strap)) [*6]
        |-> crossover_en == crossover_auto_strap)
        else $error("crossover does not follow strap");
    AST_SPEED: assert property (!sys_reset_out [*5] |-> $stable(link_speed_100))
        else $error("speed changed outside reset");
    AST_DEFAULTS: assert property (link_autoneg_en == link_speed_100 && !link_full_duplex)
        else $error("default link settings wrong");
    AST_WAKE_DRV: assert property (wake_indicator_out |-> wake_indicator_oe)
        else $error("wake output high while not driven");
endmodule

bind rwsc_top rwsc_top_asserts u_chk (.ref_clk, .rst_n, .hw_reset_pin_low, .chip_select_low,
    .write_strobe_low, .crossover_auto_strap, .wake_event_in, .reg_wr, .wake_indicator_out,
    .wake_indicator_oe, .crossover_en, .link_speed_100, .link_full_duplex, .link_autoneg_en,
    .power_save, .sys_reset_out);

// ===== rwsc_host_pins.sv
// host cpu pin model making one wake-up write cycle
`timescale 1ns/100ps
module rwsc_host_pins (
    input logic ref_clk,
    input logic wake_req,
    output logic chip_select_low,
    output logic write_strobe_low
);
    int hold_cnt = 0;
    // the cycle stands for a write to the byte test word; pull-ups keep pins high
    always @(posedge ref_clk) begin
        if (wake_req && hold_cnt == 0) begin
            hold_cnt <= 10;
        end else if (hold_cnt != 0) begin
            hold_cnt <= hold_cnt - 1;
        end
    end
    // select and strobe go low together
    assign chip_select_low = (hold_cnt == 0);
    assign write_strobe_low = (hold_cnt == 0);
endmodule

// ===== rwsc_top_tb.sv
// self-checking testbench for rwsc_top
`timescale 1ns/100ps
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin error_cnt++; \
    $display("[ERR] %0t got %h exp %h", $time, a, e); end end
module rwsc_top_tb;
    typedef struct {logic [7:0] wa; logic [31:0] wd; logic [7:0] ra; logic [31:0] ex;} rwsc_row_t;
    localparam logic [31:0] BT = 32'h1234_5678; // arbitrary test pattern
    logic ref_clk = 0, rst_n = 0, hw_reset_pin_low = 1, crossover_auto_strap = 1;
    logic speed_sel_strap = 1, ref_osc_in = 0, wake_event_in = 0, reg_wr = 0, reg_rd = 0;
    logic wake_req = 0, chip_select_low, write_strobe_low, irq_out, wake_indicator_out;
    logic wake_indicator_oe, ref_osc_out, crossover_en, link_speed_100, link_full_duplex;
    logic link_autoneg_en, power_save, sys_reset_out;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0000_0000, reg_rdata, rd_q;
    int error_cnt = 0, n_checks = 0, cyc = 0;
    // write, read-back address, expected word; the first write hits the lock
    rwsc_row_t rows[6] = '{
        '{8'h00, 32'h0000_0001, 8'h00, 32'h0000_0000},
        '{8'h00, 32'h0000_0003, 8'h00, 32'h0000_0003},
        '{8'h10, 32'h0000_0000, 8'h10, BT},
        '{8'h0c, 32'hffff_ffff, 8'h0c, 32'h0000_005c},
        '{8'h20, 32'hffff_ffff, 8'h20, 32'h0000_0000},
        '{8'h08, 32'h0000_0003, 8'h08, 32'h0000_0003}};

    rwsc_top #(.BYTE_TEST_VAL(BT), .POR_TICKS(4)) dut (.ref_clk, .rst_n, .hw_reset_pin_low,
        .chip_select_low, .write_strobe_low, .crossover_auto_strap, .speed_sel_strap,
        .ref_osc_in, .wake_event_in, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .irq_out, .wake_indicator_out, .wake_indicator_oe, .ref_osc_out, .crossover_en,
        .link_speed_100, .link_full_duplex, .link_autoneg_en, .power_save, .sys_reset_out);
    rwsc_host_pins host (.ref_clk, .wake_req, .chip_select_low, .write_strobe_low);

    // 100 MHz clock and 25 MHz reference oscillator
    always #5 ref_clk = ~ref_clk;
    always #20 ref_osc_in = ~ref_osc_in;

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        reg_wr <= 1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr <= 0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge ref_clk);
        reg_rd <= 1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd <= 0;
        #1 rd_q = reg_rdata;
    endtask
    task automatic wait_rdy();
        for (int i = 0; i < 300 && sys_reset_out !== 1'b0; i++) @(posedge ref_clk);
        #1;
        `CHK(sys_reset_out, 1'b0)
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    task automatic complete_run();
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // cycle ceiling against a hang
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 5000) begin
            error_cnt++;
            complete_run();
        end
    end

    initial begin
        settle(2);
        `CHK({sys_reset_out, power_save}, 2'b10)
        rst_n <= 1;
        wait_rdy();
        `CHK({crossover_en, link_speed_100, link_autoneg_en}, 3'b111)
        foreach (rows[i]) begin
            wr(rows[i].wa, rows[i].wd);
            rd(rows[i].ra);
            `CHK(rd_q, rows[i].ex)
        end
        // sleep, then a wake event must not wake the device
        wr(8'h00, 32'h0000_000b);
        settle(6);
        `CHK(power_save, 1'b1)
        @(posedge ref_clk) wake_event_in <= 1;
        @(posedge ref_clk) wake_event_in <= 0;
        settle(4);
        `CHK({power_save, wake_indicator_out, wake_indicator_oe, irq_out}, 4'b1111)
        @(posedge ref_clk) wake_req <= 1;
        @(posedge ref_clk) wake_req <= 0;
        settle(14);
        `CHK(power_save, 1'b0)
        wr(8'h08, 32'h0000_0000);
        rd(8'h08);
        `CHK(rd_q, 32'h0000_0003)
        rd(8'h04);
        `CHK(rd_q, 32'h0000_0003)
        // open drain, active low, then clear and mask
        wr(8'h00, 32'h0000_0005);
        settle(2);
        `CHK({wake_indicator_out, wake_indicator_oe}, 2'b01)
        wr(8'h04, 32'h0000_0001);
        settle(2);
        `CHK({wake_indicator_out, wake_indicator_oe, irq_out}, 3'b001)
        wr(8'h08, 32'h0000_0001);
        settle(2);
        `CHK(irq_out, 1'b0)
        // bus wake through the byte test word
        wr(8'h00, 32'h0000_0008);
        settle(2);
        `CHK(power_save, 1'b1)
        wr(8'h10, 32'h0000_0000);
        settle(2);
        `CHK(power_save, 1'b0)
        // straps move, then the reset pin latches the new speed
        @(posedge ref_clk) speed_sel_strap <= 0;
        crossover_auto_strap <= 0;
        settle(10);
        `CHK({crossover_en, link_speed_100}, 2'b01)
        @(posedge ref_clk) hw_reset_pin_low <= 0;
        settle(10);
        `CHK(sys_reset_out, 1'b1)
        @(posedge ref_clk) hw_reset_pin_low <= 1;
        wait_rdy();
        wr(8'h00, 32'h0000_0001);
        rd(8'h00);
        `CHK(rd_q, 32'h0000_0000)
        `CHK({link_speed_100, link_autoneg_en, link_full_duplex}, 3'b000)
        complete_run();
    end
endmodule
